// ===== include/psd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PSD_MAP_SVH
`define PSD_MAP_SVH
`define PSD_CTRL_OFS     8'h00
`define PSD_STAT_OFS     8'h04
`define PSD_CTRL_INH_BIT 0
`define PSD_CTRL_RST     1'b0
`define PSD_ST_SLEEP_BIT 0
`define PSD_ST_ILV_BIT   1
`define PSD_ST_DRV_BIT   2
`define PSD_ST_WR_BIT    3
`define PSD_ST_CNT_LSB   4
`define PSD_SLEEP_CYC    2'd2
`endif

// ===== include/psd_mem_if.sv
// Carrier between the port logic and its storage array
`timescale 1ns/1ps
interface psd_mem_if #(parameter int AW = 18, parameter int DW = 36, parameter int LANES = 4);
    logic             rdEn;    // Read strobe
    logic [AW-1:0]    rdAddr;  // Read address
    logic [DW-1:0]    rdData;  // Registered read data
    logic             wrEn;    // Write strobe
    logic [AW-1:0]    wrAddr;  // Write address
    logic [LANES-1:0] wrLane;  // Lanes to update
    logic [DW-1:0]    wrData;  // Write word
    modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrLane, wrData, input rdData);
    modport mem  (input rdEn, rdAddr, wrEn, wrAddr, wrLane, wrData, output rdData);
endinterface : psd_mem_if

// ===== include/psd_pkg.sv
// Types shared by the data-port design
package psd_pkg;
    // Sleep sequencing, one-hot
    typedef enum logic [3:0] {
        SLP_AWAKE  = 4'b0001,
        SLP_ENTER  = 4'b0010,
        SLP_ASLEEP = 4'b0100,
        SLP_LEAVE  = 4'b1000
    } psd_sleep_t;
    // Register selected by a bus address
    typedef enum logic [1:0] {
        REG_NONE = 2'b00,
        REG_CTRL = 2'b01,
        REG_STAT = 2'b10
    } psd_reg_t;
endpackage : psd_pkg

// ===== rtl/psd_mem.sv
// Storage array with lane write and registered read
`timescale 1ns/1ps
module psd_mem #(
    parameter int AW    = 18,
    parameter int LANES = 4,
    parameter int LW    = 9
) (
    // Clock
    input wire logic clk,
    // Port
    psd_mem_if.mem   mp
);
    // Contents survive sleep because nothing ever clears them
    logic [LANES*LW-1:0] store [2**AW];

    // Read data out of a register
    always_ff @(posedge clk) begin
        if (mp.rdEn) begin
            mp.rdData <= store[mp.rdAddr];
        end
    end

    // One write enable per lane; a single process keeps the array to one driver
    always_ff @(posedge clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (mp.wrEn && mp.wrLane[g]) begin
                store[mp.wrAddr][g*LW +: LW] <= mp.wrData[g*LW +: LW];
            end
        end
    end
endmodule : psd_mem

// ===== rtl/psd_top.sv
// Pipelined burst SRAM data port with AHB-Lite control registers
//
// Operation
// - Input data captured on rising edge
// - Read drives data of previously sampled address
// - Drive only while output enable low
// - Three-state during every write data phase
// - Parity lanes behave like data lanes
// - Parity lane gated by same-letter select
// - Strap high interleaved, low linear order
// - Floating strap counts as high
// - Sleep input retains contents, stops access
// - Active-low byte selects sampled with clock
// - Qualifier high freezes access pipeline; sleep, lane enables, AHB keep running
// - No drive while or after deselected
// - Two cycles to enter, leave sleep
`timescale 1ns/1ps
`include "psd_map.svh"
module psd_top #(
    parameter int AW    = 18,
    parameter int LANES = 4,
    parameter int DBW   = 8
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Memory pins, controller side
    input  wire logic               clock_qualifier_n,
    input  wire logic               chipEn1N,
    input  wire logic               chipEn2,
    input  wire logic               chipEn3N,
    input  wire logic               writeEnN,
    input  wire logic               advLoad,
    input  wire logic [AW-1:0]      addr,
    input  wire logic [LANES-1:0]   byte_write_select_n,
    input  wire logic               outEnN,
    input  wire logic               sleep_request,
    input  wire logic               modeStrap,
    input  wire logic               modeFloat,
    // Data and parity lanes, split three ways
    input  wire logic [LANES*DBW-1:0] dataIn,
    input  wire logic [LANES-1:0]   parity_lanes_in,
    output logic [LANES*DBW-1:0]    dataOut,
    output logic [LANES-1:0]        parity_lanes_out,
    output logic [LANES-1:0]        laneOeN,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata
);
    localparam int LW = DBW + 1;
    localparam int DW = LANES * LW;

    //------------------------------------------------------------
    // Parameter checks
    //------------------------------------------------------------
    if (AW < 2 || LANES < 1 || DBW < 1) begin : gBadParam
        $error("psd_top: parameters out of range");
    end

    //------------------------------------------------------------
    // Storage
    //------------------------------------------------------------
    psd_mem_if #(.AW(AW), .DW(DW), .LANES(LANES)) memBus ();
    psd_mem #(.AW(AW), .LANES(LANES), .LW(LW)) uMem (
        .clk (clk),
        .mp  (memBus.mem)
    );

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    psd_pkg::psd_sleep_t sleepSt_q, sleepSt_d; // Sleep sequencer
    logic [1:0]       sleepCnt_q, sleepCnt_d;  // Cycles in transition
    logic             s1Valid_q, s1Write_q;    // Op sampled last edge
    logic [AW-1:0]    s1Addr_q;
    logic [LANES-1:0] s1BwN_q;
    logic             s2Valid_q, s2Write_q;    // Op in data phase
    logic [AW-1:0]    s2Addr_q;
    logic [LANES-1:0] s2BwN_q;
    logic [1:0]       burstStart_q, burstCnt_q; // Burst origin, step
    logic             burstValid_q, burstWrite_q;
    logic [DW-1:0]    outWord_q;               // Output register
    logic [LANES-1:0] laneOeN_q;               // Low while driving
    logic             ctrlInh_q;               // Software drive inhibit
    logic             dpWrite_q;               // AHB data phase write
    psd_pkg::psd_reg_t dpReg_q;                // AHB data phase target
    logic [31:0]      hrdata_q;

    //------------------------------------------------------------
    // Access decode
    //------------------------------------------------------------
    wire qual      = !clock_qualifier_n;
    wire awake     = (sleepSt_q == psd_pkg::SLP_AWAKE);
    wire selAll    = !chipEn1N && chipEn2 && !chipEn3N;
    wire loadNew   = !advLoad;
    wire ilv       = modeStrap || modeFloat;
    wire [1:0] nextCnt = burstCnt_q + 2'd1;
    wire [1:0] burstLow = ilv ? (burstStart_q ^ nextCnt) : (burstStart_q + nextCnt);
    wire [AW-1:0] accAddr = loadNew ? addr : {s1Addr_q[AW-1:2], burstLow};
    wire accValid  = awake && (loadNew ? selAll : burstValid_q);
    wire accWrite  = loadNew ? !writeEnN : burstWrite_q;
    wire nextRead  = qual ? (s1Valid_q && !s1Write_q) : (s2Valid_q && !s2Write_q);
    // enable gate, asleep, deselect keeps lanes off
    wire driveNext = nextRead && !outEnN && !ctrlInh_q && awake;

    //------------------------------------------------------------
    // Memory strobes
    //------------------------------------------------------------
    // read issued at address edge
    assign memBus.rdEn   = qual && accValid && !accWrite;
    assign memBus.rdAddr = accAddr;
    assign memBus.wrEn   = qual && awake && s2Valid_q && s2Write_q;
    assign memBus.wrAddr = s2Addr_q;
    // lane select gates data and parity
    assign memBus.wrLane = ~s2BwN_q;

    for (genvar g = 0; g < LANES; g++) begin : gPack
        assign memBus.wrData[g*LW +: LW] = {parity_lanes_in[g], dataIn[g*DBW +: DBW]};
        assign dataOut[g*DBW +: DBW]     = outWord_q[g*LW +: DBW];
        assign parity_lanes_out[g]       = outWord_q[g*LW + DBW];
    end
    assign laneOeN = laneOeN_q;

    //------------------------------------------------------------
    // Sleep sequencer
    //------------------------------------------------------------
    // two cycles each way
    always_comb begin
        sleepSt_d  = sleepSt_q;
        sleepCnt_d = 2'd0;
        case (sleepSt_q)
            psd_pkg::SLP_AWAKE: begin
                if (sleep_request) begin
                    sleepSt_d  = psd_pkg::SLP_ENTER;
                    sleepCnt_d = 2'd1;
                end
            end
            psd_pkg::SLP_ENTER: begin
                if (!sleep_request) begin
                    sleepSt_d = psd_pkg::SLP_AWAKE;
                end else if (sleepCnt_q + 2'd1 >= `PSD_SLEEP_CYC) begin
                    sleepSt_d = psd_pkg::SLP_ASLEEP;
                end else begin
                    sleepCnt_d = sleepCnt_q + 2'd1;
                end
            end
            psd_pkg::SLP_ASLEEP: begin
                if (!sleep_request) begin
                    sleepSt_d  = psd_pkg::SLP_LEAVE;
                    sleepCnt_d = 2'd1;
                end
            end
            psd_pkg::SLP_LEAVE: begin
                if (sleepCnt_q + 2'd1 >= `PSD_SLEEP_CYC) begin
                    sleepSt_d = psd_pkg::SLP_AWAKE;
                end else begin
                    sleepCnt_d = sleepCnt_q + 2'd1;
                end
            end
            default: begin
                sleepSt_d = psd_pkg::SLP_AWAKE;
            end
        endcase
    end

    // Sleep runs on every edge: its input does not wait for the qualifier
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleepSt_q  <= psd_pkg::SLP_AWAKE;
            sleepCnt_q <= 2'd0;
        end else begin
            sleepSt_q  <= sleepSt_d;
            sleepCnt_q <= sleepCnt_d;
        end
    end

    //------------------------------------------------------------
    // Access pipeline
    //------------------------------------------------------------
    // qualifier high holds everything except the lane enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1Valid_q <= 1'b0;
            s1Write_q <= 1'b0;
            s1Addr_q  <= '0;
            s1BwN_q   <= '1;
            s2Valid_q <= 1'b0;
            s2Write_q <= 1'b0;
            s2Addr_q  <= '0;
            s2BwN_q   <= '1;
        end else if (qual) begin
            s1Valid_q <= accValid;
            s1Write_q <= accWrite;
            s1Addr_q  <= accAddr;
            s1BwN_q   <= byte_write_select_n;
            s2Valid_q <= s1Valid_q && awake;
            s2Write_q <= s1Write_q;
            s2Addr_q  <= s1Addr_q;
            s2BwN_q   <= s1BwN_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burstStart_q <= 2'd0;
            burstCnt_q   <= 2'd0;
            burstValid_q <= 1'b0;
            burstWrite_q <= 1'b0;
        end else if (qual && loadNew) begin
            burstStart_q <= addr[1:0];
            burstCnt_q   <= 2'd0;
            burstValid_q <= accValid;
            burstWrite_q <= !writeEnN;
        end else if (qual) begin
            burstCnt_q   <= nextCnt;
            burstValid_q <= accValid;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outWord_q <= '0;
        end else if (qual && s1Valid_q && !s1Write_q) begin
            outWord_q <= memBus.rdData;
        end
    end

    // write phase never drives, same enable per lane
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            laneOeN_q <= '1;
        end else begin
            laneOeN_q <= {LANES{!driveNext}};
        end
    end

    //------------------------------------------------------------
    // AHB-Lite registers
    //------------------------------------------------------------
    function automatic psd_pkg::psd_reg_t regOf(input logic [31:0] a);
        if (a[7:0] == `PSD_CTRL_OFS && a[31:8] == 24'h000000) begin
            return psd_pkg::REG_CTRL;
        end else if (a[7:0] == `PSD_STAT_OFS && a[31:8] == 24'h000000) begin
            return psd_pkg::REG_STAT;
        end
        return psd_pkg::REG_NONE;
    endfunction : regOf

    wire addrPh = hsel && htrans[1] && hready;
    wire [31:0] statusWord = 32'h0 | (32'(sleepSt_q != psd_pkg::SLP_AWAKE) << `PSD_ST_SLEEP_BIT)
                           | (32'(ilv) << `PSD_ST_ILV_BIT) | (32'(!laneOeN_q[0]) << `PSD_ST_DRV_BIT)
                           | (32'(s2Valid_q && s2Write_q) << `PSD_ST_WR_BIT)
                           | (32'(burstCnt_q) << `PSD_ST_CNT_LSB);
    wire [31:0] readWord = (regOf(haddr) == psd_pkg::REG_CTRL) ? 32'(ctrlInh_q) << `PSD_CTRL_INH_BIT :
                           (regOf(haddr) == psd_pkg::REG_STAT) ? statusWord : 32'h0;

    // Zero-wait slave; reads are taken in the address phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dpWrite_q <= 1'b0;
            dpReg_q   <= psd_pkg::REG_NONE;
            hrdata_q  <= 32'h0;
            ctrlInh_q <= `PSD_CTRL_RST;
        end else begin
            dpWrite_q <= addrPh && hwrite;
            dpReg_q   <= addrPh ? regOf(haddr) : psd_pkg::REG_NONE;
            hrdata_q  <= (addrPh && !hwrite) ? readWord : 32'h0;
            if (dpWrite_q && dpReg_q == psd_pkg::REG_CTRL) begin
                ctrlInh_q <= hwdata[`PSD_CTRL_INH_BIT];
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    readData_a: assert property (@(posedge clk) disable iff (!rstn)
        qual && s1Valid_q && !s1Write_q |=> outWord_q == $past(memBus.rdData))
        else $error("read word not loaded");
    oeHigh_a: assert property (@(posedge clk) disable iff (!rstn)
        outEnN |=> &laneOeN_q)
        else $error("lanes driven with enable high");
    writeOff_a: assert property (@(posedge clk) disable iff (!rstn)
        s2Valid_q && s2Write_q |-> &laneOeN_q)
        else $error("lanes driven in write phase");
    laneSame_a: assert property (@(posedge clk) disable iff (!rstn)
        laneOeN_q == {LANES{laneOeN_q[0]}})
        else $error("lane enables differ");
    laneGate_a: assert property (@(posedge clk) disable iff (!rstn)
        qual && accValid && accWrite && loadNew ##1 qual && awake ##1 qual && awake
            |-> memBus.wrEn && memBus.wrLane == ~$past(byte_write_select_n, 2))
        else $error("write lanes wrong");
    burstStep_a: assert property (@(posedge clk) disable iff (!rstn)
        qual && advLoad |=> s1Addr_q[1:0] == ($past(ilv) ? ($past(burstStart_q) ^ $past(nextCnt))
                                                        : $past(burstStart_q) + $past(nextCnt)))
        else $error("burst order wrong");
    strapFloat_a: assert property (@(posedge clk) disable iff (!rstn)
        modeFloat |-> ilv)
        else $error("floating strap not interleaved");
    holdState_a: assert property (@(posedge clk) disable iff (!rstn)
        !qual |=> $stable(s1Addr_q) && $stable(s2Valid_q) && $stable(outWord_q) && $stable(burstCnt_q))
        else $error("state moved while unqualified");
    deselOff_a: assert property (@(posedge clk) disable iff (!rstn)
        qual && !accValid ##1 qual |=> &laneOeN_q)
        else $error("drive after deselect");
    sleepIn_a: assert property (@(posedge clk) disable iff (!rstn)
        sleepSt_q == psd_pkg::SLP_AWAKE && sleep_request ##1 sleep_request |=> sleepSt_q == psd_pkg::SLP_ASLEEP)
        else $error("sleep entry not two cycles");
    sleepOff_a: assert property (@(posedge clk) disable iff (!rstn)
        sleepSt_q == psd_pkg::SLP_ASLEEP |=> &laneOeN_q && !memBus.wrEn)
        else $error("activity while asleep");
endmodule : psd_top

// ===== sim/psd_ctl_model.sv
// Memory controller model that drives the data-port pins
`timescale 1ns/1ps
module psd_ctl_model (
    // Clock and device side
    input  wire logic        clk,
    input  wire logic [3:0]  laneOeN,
    input  wire logic [35:0] devWord,
    // Controller pins
    output logic             clock_qualifier_n,
    output logic             chipEn1N,
    output logic             writeEnN,
    output logic             advLoad,
    output logic [17:0]      addr,
    output logic [3:0]       byte_write_select_n,
    output logic             outEnN,
    output logic             sleep_request,
    output logic             modeStrap,
    output logic             modeFloat,
    // Resolved parity and data lanes
    output wire logic [35:0] busWord
);
    logic [1:0]  stK [3];   // Stage kind: 0 idle, 1 read, 2 write
    logic [35:0] stE [3];   // Stage word
    logic        burstWr;   // Advance keeps the type of its burst
    logic        drv;       // Model drives the lanes
    logic [35:0] drvW;      // Last word driven
    logic [1:0]  doneK;     // Operation maturing now
    logic [35:0] doneE;     // Its word
    logic [3:0]  seenOe;    // Lane enables seen then
    logic [35:0] seenW;     // Device word seen then

    // A released bus shows the inverse of the last word, so a stale copy never passes
    assign busWord = (laneOeN != 4'hf) ? devWord : (drv ? drvW : ~drvW);

    // Idle, deselected pins at time zero
    initial begin
        clock_qualifier_n = 1'b0;
        chipEn1N = 1'b1;
        writeEnN = 1'b1;
        advLoad = 1'b0;
        addr = 18'h0;
        byte_write_select_n = 4'hf;
        outEnN = 1'b0;
        sleep_request = 1'b0;
        modeStrap = 1'b1;
        modeFloat = 1'b0;
        drv = 1'b0;
        drvW = 36'h0;
        burstWr = 1'b0;
        stK = '{default: 2'd0};
        stE = '{default: 36'h0};
    end

    // One cycle: k 0 idle, 1 read, 2 write, 3 advance; fr stops the clock qualifier
    task automatic cyc(input logic [1:0] k, input logic [17:0] a, input logic [3:0] bw,
                       input logic [35:0] e, input logic fr);
        @(posedge clk);
        seenOe = laneOeN;
        seenW = devWord;
        doneK = stK[2];
        doneE = stE[2];
        if (k != 2'd3)
            burstWr = (k == 2'd2);
        // Edges seen with the qualifier high move nothing; the offered operation is replaced
        if (!clock_qualifier_n) begin
            stK[2] = stK[1];
            stE[2] = stE[1];
            stK[1] = stK[0];
            stE[1] = stE[0];
        end
        stK[0] = (k == 2'd3) ? {burstWr, !burstWr} : k;
        stE[0] = e;
        clock_qualifier_n <= fr;
        chipEn1N <= (k == 2'd0);
        writeEnN <= (k != 2'd2);
        advLoad <= (k == 2'd3);
        addr <= a;
        // selects ride with the address phase
        byte_write_select_n <= bw;
        // Write word goes out for the edge two cycles after its address
        drv <= (stK[2] == 2'd2);
        if (stK[2] == 2'd2)
            drvW <= stE[2];
    endtask : cyc

    // strap and levels change only with the pipeline idle
    task automatic setPins(input logic oe, input logic slp, input logic strap, input logic flt);
        @(posedge clk);
        outEnN <= oe;
        sleep_request <= slp;
        modeStrap <= strap;
        modeFloat <= flt;
    endtask : setPins
endmodule : psd_ctl_model

// ===== sim/tb_pipelined_sram_data_port.sv
// Self-checking testbench for the pipelined SRAM data port
`timescale 1ns/1ps
`include "psd_map.svh"
module tb_pipelined_sram_data_port;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [35:0] W1 = 36'h9_a5c3_1e7f;  // Test words, parity on top
    localparam logic [35:0] W2 = 36'h6_5a3c_e180;
    logic        clk, rstn;                           // Clock, reset
    logic        hsel, hwrite, hreadyout, hresp;      // AHB-Lite
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        clock_qualifier_n, chipEn1N, writeEnN, advLoad, outEnN;
    logic        sleep_request, modeStrap, modeFloat;
    logic [17:0] addr;
    logic [3:0]  byte_write_select_n, parity_lanes_out, laneOeN;
    logic [31:0] dataOut;
    wire  [35:0] busWord;                             // Resolved lanes
    int          failures, nTests;                    // Mismatches, comparisons
    logic        oeOff, ilv;                          // Reads not driven; order

    psd_top i_psd_top (
        .clk(clk), .rstn(rstn), .clock_qualifier_n(clock_qualifier_n), .chipEn1N(chipEn1N),
        .chipEn2(1'b1), .chipEn3N(1'b0), .writeEnN(writeEnN), .advLoad(advLoad), .addr(addr),
        .byte_write_select_n(byte_write_select_n), .outEnN(outEnN), .sleep_request(sleep_request),
        .modeStrap(modeStrap), .modeFloat(modeFloat), .dataIn(busWord[31:0]),
        .parity_lanes_in(busWord[35:32]), .dataOut(dataOut), .parity_lanes_out(parity_lanes_out),
        .laneOeN(laneOeN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    psd_ctl_model i_psd_ctl_model (
        .clk(clk), .laneOeN(laneOeN), .devWord({parity_lanes_out, dataOut}),
        .clock_qualifier_n(clock_qualifier_n), .chipEn1N(chipEn1N), .writeEnN(writeEnN),
        .advLoad(advLoad), .addr(addr), .byte_write_select_n(byte_write_select_n), .outEnN(outEnN),
        .sleep_request(sleep_request), .modeStrap(modeStrap), .modeFloat(modeFloat), .busWord(busWord));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for hready; running out ends the run
    task automatic waitReady;
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (hreadyout !== 1'b1 && t < 64);
        if (hreadyout !== 1'b1) begin
            failures++;
            report_and_stop();
        end
    endtask : waitReady

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        htrans <= 2'b10;
        waitReady();
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady();
        d = hrdata;
    endtask : ahb

    // One pin cycle; judges the operation maturing in it
    task automatic op(input logic [1:0] k, input logic [17:0] a = 18'h0, input logic [3:0] bw = 4'h0,
                      input logic [35:0] e = 36'h0, input logic fr = 1'b0);
        logic rdOn;
        i_psd_ctl_model.cyc(k, a, bw, e, fr);
        rdOn = (i_psd_ctl_model.doneK == 2'd1) && !oeOff;
        if (rdOn)
            chk(i_psd_ctl_model.seenW, i_psd_ctl_model.doneE);
        chk(36'(i_psd_ctl_model.seenOe), rdOn ? 36'h0 : 36'hf);
    endtask : op

    task automatic flush;
        repeat (3) op(2'd0);
    endtask : flush

    // Level pins change only after the pipeline has drained
    task automatic pins(input logic oe, input logic slp, input logic strap, input logic flt);
        flush();
        i_psd_ctl_model.setPins(oe, slp, strap, flt);
    endtask : pins

    function automatic logic [35:0] val(input logic [17:0] a);
        return {a[3:0], 14'h1a5, a};
    endfunction : val

    function automatic logic [35:0] laneM(input int g);
        return (36'hff << (8 * g)) | (36'h1 << (32 + g));
    endfunction : laneM

    function automatic logic [17:0] bAddr(input logic [17:0] s, input logic [1:0] k, input logic il);
        return {s[17:2], il ? (s[1:0] ^ k) : (s[1:0] + k)};
    endfunction : bAddr

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        failures = 0;
        nTests = 0;
        oeOff = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({parity_lanes_out, dataOut}, 36'h0);
        chk(36'(laneOeN), 36'hf);
        chk(36'({hresp, hreadyout}), 36'h1);
        ahb(1'b0, `PSD_CTRL_OFS, 32'h0, rd);
        chk(36'(rd), 36'h0);
        ahb(1'b0, `PSD_STAT_OFS, 32'h0, rd);
        chk(36'(rd[3:0]), 36'h2);
        ahb(1'b1, 32'h0000_0010, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h0000_0010, 32'h0, rd);
        chk(36'(rd), 36'h0);
        $display("test reset and registers done");
        op(2'd2, 18'h10, 4'h0, W1);
        op(2'd2, 18'h11, 4'h0, W2);
        op(2'd0);
        op(2'd0);
        op(2'd1, 18'h10, 4'h0, W1);
        op(2'd1, 18'h11, 4'h0, W2);
        flush();
        $display("test word access done");
        for (int g = 0; g < 4; g++)
            op(2'd2, 18'h20 + 18'(g), 4'h0, 36'h0);
        for (int g = 0; g < 4; g++)
            op(2'd2, 18'h20 + 18'(g), ~(4'h1 << g), 36'hf_ffff_ffff);
        op(2'd0);
        op(2'd0);
        for (int g = 0; g < 4; g++)
            op(2'd1, 18'h20 + 18'(g), 4'h0, laneM(g));
        flush();
        $display("test byte lanes done");
        for (int a = 'h30; a < 'h34; a++)
            op(2'd2, 18'(a), 4'h0, val(18'(a)));
        for (int m = 0; m < 3; m++) begin
            ilv = (m != 0);
            pins(1'b0, 1'b0, m == 1, m == 2);
            ahb(1'b0, `PSD_STAT_OFS, 32'h0, rd);
            chk(36'(rd[`PSD_ST_ILV_BIT]), 36'(ilv));
            op(2'd1, 18'h33, 4'h0, val(18'h33));
            for (int k = 1; k < 4; k++)
                op(2'd3, 18'h0, 4'h0, val(bAddr(18'h33, 2'(k), ilv)));
            flush();
        end
        $display("test burst order done");
        pins(1'b1, 1'b0, 1'b1, 1'b0);
        oeOff = 1'b1;
        op(2'd1, 18'h10, 4'h0, W1);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        ahb(1'b1, `PSD_CTRL_OFS, 32'h1, rd);
        op(2'd1, 18'h10, 4'h0, W1);
        flush();
        ahb(1'b1, `PSD_CTRL_OFS, 32'h0, rd);
        oeOff = 1'b0;
        $display("test output enable done");
        op(2'd1, 18'h11, 4'h0, W2);
        op(2'd0);
        op(2'd0, 18'h0, 4'h0, 36'h0, 1'b1);
        repeat (3) @(posedge clk);
        op(2'd0);
        repeat (5) op(2'd0);
        $display("test clock qualifier done");
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        oeOff = 1'b1;
        repeat (2) @(posedge clk);
        ahb(1'b0, `PSD_STAT_OFS, 32'h0, rd);
        chk(36'(rd[`PSD_ST_SLEEP_BIT]), 36'h1);
        op(2'd2, 18'h10, 4'h0, W2);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        ahb(1'b0, `PSD_STAT_OFS, 32'h0, rd);
        chk(36'(rd[`PSD_ST_SLEEP_BIT]), 36'h0);
        oeOff = 1'b0;
        op(2'd1, 18'h10, 4'h0, W1);
        flush();
        $display("test sleep done");
        report_and_stop();
    end
endmodule : tb_pipelined_sram_data_port
